// *** verilog/lvds_pixel_serializer.sv ***
// Serializer from a display controller's parallel pixels onto lanes.
// Assumes pixel clocks well below the system clock; all controller
// pins are asynchronous and are synchronised before use.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Each lane carries seven bits per pixel
// RULE_02: 18-bit uses three lanes incl. sync, enable
// RULE_03: 24-bit adds six colour bits on lane 3
// RULE_04: LSB mapping puts colour bits 1:0 on lane 3
// RULE_05: MSB mapping puts colour bits 7:6 on lane 3
// RULE_06: Map select 0 picks LSB-on-lane-3 mapping
// RULE_07: Map select 6 picks MSB-on-lane-3 mapping
// RULE_08: Depth and mapping are software configurable
// RULE_09: Only channel A driven, no channel B
// RULE_10: Pixel clock at most 165 MHz; code needs eight system cycles per pixel, so 1.25 MHz at a 10 MHz system clock
// RULE_11: Either of two controllers may feed us
// RULE_12: Clock pair plus lanes 0-3, lane 3 24-bit only
// RULE_13: Clock pair fixed pattern over seven slots
module lvds_pixel_serializer
    import lvds_pixel_serializer_pkg::*;
(
    // System
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // Avalon-MM slave
    input  wire logic [3:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    // Display controller 0
    input  wire logic        ctrl0_pixel_clk_in,
    input  wire logic [23:0] ctrl0_rgb_in,
    input  wire logic        ctrl0_de_in,
    input  wire logic        ctrl0_vsync_in,
    input  wire logic        ctrl0_hsync_in,
    // Display controller 1
    input  wire logic        ctrl1_pixel_clk_in,
    input  wire logic [23:0] ctrl1_rgb_in,
    input  wire logic        ctrl1_de_in,
    input  wire logic        ctrl1_vsync_in,
    input  wire logic        ctrl1_hsync_in,
    // Channel A serial lines
    output logic             channel_a_clock_pair_out,
    output logic             channel_a_lane0_out,
    output logic             channel_a_lane1_out,
    output logic             channel_a_lane2_out,
    output logic             channel_a_lane3_out
);

    // Channel B has no ports at all: single channel only. see RULE_09

    // Pixel word to four 7-bit lane words, slot 6 sent first
    function automatic logic [27:0] map_lanes(
        input logic [PIX_W-1:0] pix,
        input logic             depth24,
        input logic [2:0]       map_sel
    );
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic       de;
        logic       vs;
        logic       hs;
        logic [5:0] r6;
        logic [5:0] g6;
        logic [5:0] b6;
        logic [1:0] rx;
        logic [1:0] gx;
        logic [1:0] bx;
        logic [6:0] l0;
        logic [6:0] l1;
        logic [6:0] l2;
        logic [6:0] l3;
        r  = pix[26:19];
        g  = pix[18:11];
        b  = pix[10:3];
        de = pix[2];
        vs = pix[1];
        hs = pix[0];
        if (depth24 && map_sel == MAP_MSB_FOURTH) begin
            // Not 18-bit compatible: 24-bit panels only. see RULE_05 RULE_07
            r6 = r[5:0];
            g6 = g[5:0];
            b6 = b[5:0];
            rx = r[7:6];
            gx = g[7:6];
            bx = b[7:6];
        end else begin
            // Lanes 0-2 equal 18-bit output. see RULE_04 RULE_06
            r6 = r[7:2];
            g6 = g[7:2];
            b6 = b[7:2];
            rx = r[1:0];
            gx = g[1:0];
            bx = b[1:0];
        end
        // Three lanes hold colour, enable and syncs. see RULE_02
        l0 = {g6[0], r6[5:0]};
        l1 = {b6[1:0], g6[5:1]};
        l2 = {de, vs, hs, b6[5:2]};
        // Extra colour bits on lane 3 in 24-bit only. see RULE_03 RULE_12
        l3 = depth24 ? {1'b0, bx, gx, rx} : 7'h00;
        return {l3, l2, l1, l0};
    endfunction

    // Configuration and bus state
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic        waitreq_r;
    logic        waitreq_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [15:0] pixcnt_r;
    logic [15:0] pixcnt_nxt;
    logic [7:0]  active_r;
    logic [7:0]  active_nxt;

    // Input synchroniser and edge detect
    logic [2*PIX_W+1:0] raw_all;
    logic [2*PIX_W+1:0] sync1_r;
    logic [2*PIX_W+1:0] sync2_r;
    logic [PIX_W:0]     sel_sync;
    logic               pclk_d_r;
    logic               capture;

    // Serializer state
    ser_state_e  state_r;
    ser_state_e  state_nxt;
    logic [2:0]  slot_r;
    logic [2:0]  slot_nxt;
    logic [27:0] word_r;
    logic [27:0] word_nxt;
    logic [6:0]  clkpat_r;
    logic [6:0]  clkpat_nxt;
    logic [4:0]  out_r;
    logic [4:0]  out_nxt;

    // Both sources synchronised, then chosen: no logic reads a raw pin.
    // Switch source only while both pixel clocks rest low.
    assign raw_all = {ctrl1_pixel_clk_in, ctrl1_rgb_in, ctrl1_de_in,
                      ctrl1_vsync_in, ctrl1_hsync_in,
                      ctrl0_pixel_clk_in, ctrl0_rgb_in, ctrl0_de_in,
                      ctrl0_vsync_in, ctrl0_hsync_in};

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            pclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= raw_all;
            sync2_r  <= sync1_r;
            pclk_d_r <= sel_sync[PIX_W];
        end
    end

    always_comb begin
        if (cfg_r[SOURCE_BIT]) begin
            sel_sync = sync2_r[2*PIX_W+1 -: PIX_W+1]; // see RULE_11
        end else begin
            sel_sync = sync2_r[PIX_W:0];
        end
    end

    // Falling pixel edge: data sampled mid-period, away from its changes.
    // Needs at least eight system cycles per pixel. see RULE_10
    assign capture = pclk_d_r && !sel_sync[PIX_W] && cfg_r[ENABLE_BIT];

    // Register bus: one wait cycle, answer on the following edge
    always_comb begin
        cfg_nxt     = cfg_r;
        waitreq_nxt = !((read_in || write_in) && waitreq_r);
        rdata_nxt   = rdata_r;
        if (write_in && !waitreq_r && address_in == CFG_ADDR) begin
            // Depth, mapping and source under software. see RULE_08
            for (int i = 0; i < 4; i++) begin
                if (byteenable_in[i]) begin
                    cfg_nxt[i*8 +: 8] = writedata_in[i*8 +: 8];
                end
            end
        end
        if (read_in && waitreq_r) begin
            unique case (address_in)
                CFG_ADDR: begin
                    rdata_nxt = cfg_r;
                end
                STATUS_ADDR: begin
                    rdata_nxt[PIXCNT_LSB +: PIXCNT_W] = pixcnt_r;
                    rdata_nxt[ACTIVE_BIT]             = (active_r != 8'h00);
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // Config written at the completing edge; read data held till next read
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_r     <= CFG_RESET;
            waitreq_r <= 1'b1;
            rdata_r   <= 32'h0000_0000;
        end else begin
            cfg_r     <= cfg_nxt;
            waitreq_r <= waitreq_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // Unused config bits are stored but ignored
    always_comb begin
        pixcnt_nxt = capture ? pixcnt_r + 16'h0001 : pixcnt_r;
        if (capture) begin
            active_nxt = ACTIVE_CNT;
        end else if (active_r != 8'h00) begin
            active_nxt = active_r - 8'h01;
        end else begin
            active_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pixcnt_r <= 16'h0000;
            active_r <= 8'h00;
        end else begin
            pixcnt_r <= pixcnt_nxt;
            active_r <= active_nxt;
        end
    end

    // Serializer: seven slots per pixel, then idle until next pixel
    always_comb begin
        state_nxt  = state_r;
        slot_nxt   = slot_r;
        word_nxt   = word_r;
        clkpat_nxt = clkpat_r;
        out_nxt    = out_r;
        if (capture) begin
            // Lanes rest low for a slot even with back-to-back pixels
            out_nxt    = {out_r[4], 4'h0};
            word_nxt   = map_lanes(sel_sync[PIX_W-1:0], cfg_r[DEPTH24_BIT],
                                   cfg_r[MAP_LSB +: MAP_W]);
            clkpat_nxt = CLOCK_PATTERN;
            slot_nxt   = 3'h0;
            state_nxt  = ST_SHIFT;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    out_nxt = {out_r[4], 4'h0};
                end
                ST_SHIFT: begin
                    // Slot 6 of each lane first. see RULE_01
                    out_nxt = {clkpat_r[6], word_r[27], word_r[20],
                               word_r[13], word_r[6]};
                    for (int l = 0; l < 4; l++) begin
                        word_nxt[l*7 +: 7] = {word_r[l*7 +: 6], 1'b0};
                    end
                    // Clock pattern marks slot positions. see RULE_13
                    clkpat_nxt = {clkpat_r[5:0], clkpat_r[6]};
                    slot_nxt   = slot_r + 3'h1;
                    if (slot_r == 3'(SLOTS - 1)) begin
                        state_nxt = ST_IDLE;
                    end
                end
            endcase
        end
        if (!cfg_r[ENABLE_BIT]) begin
            out_nxt   = 5'h00;
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r  <= ST_IDLE;
            slot_r   <= 3'h0;
            word_r   <= '0;
            clkpat_r <= 7'h00;
            out_r    <= 5'h00;
        end else begin
            state_r  <= state_nxt;
            slot_r   <= slot_nxt;
            word_r   <= word_nxt;
            clkpat_r <= clkpat_nxt;
            out_r    <= out_nxt;
        end
    end

    // Clock pair and four lanes of channel A. see RULE_12
    assign channel_a_clock_pair_out = out_r[4];
    assign channel_a_lane3_out      = out_r[3];
    assign channel_a_lane2_out      = out_r[2];
    assign channel_a_lane1_out      = out_r[1];
    assign channel_a_lane0_out      = out_r[0];
    assign readdata_out             = rdata_r;
    assign waitrequest_out          = waitreq_r;

endmodule

// *** verilog/lvds_pixel_serializer_pkg.sv ***
// Constants for the single-channel pixel serializer.
// Assumes a 10 MHz system clock and an Avalon-MM register master.
package lvds_pixel_serializer_pkg;

    // Register map, byte addresses
    localparam logic [3:0]  CFG_ADDR        = 4'h0;
    localparam logic [3:0]  STATUS_ADDR     = 4'h4;

    // serializer_custom_config fields
    localparam int          MAP_LSB         = 0;
    localparam int          MAP_W           = 3;
    localparam int          DEPTH24_BIT     = 4;
    localparam int          ENABLE_BIT      = 8;
    localparam int          SOURCE_BIT      = 9;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;

    // colour_map_select codes
    localparam logic [2:0]  MAP_LSB_FOURTH  = 3'h0;
    localparam logic [2:0]  MAP_MSB_FOURTH  = 3'h6;

    // Status fields
    localparam int          ACTIVE_BIT      = 0;
    localparam int          PIXCNT_LSB      = 16;
    localparam int          PIXCNT_W        = 16;

    // Link timing
    localparam int          SLOTS           = 7;
    localparam logic [6:0]  CLOCK_PATTERN   = 7'h63;
    localparam int          PIXCLK_MAX_MHZ  = 165;
    localparam int          SYS_CLK_MHZ     = 10;
    localparam int          ACTIVE_TIME_US  = 10;
    localparam int          ACTIVE_CYCLES   = ACTIVE_TIME_US * SYS_CLK_MHZ;
    localparam logic [7:0]  ACTIVE_CNT      = 8'(ACTIVE_CYCLES);

    // One controller's parallel word: rgb, de, vs, hs
    localparam int          PIX_W           = 27;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } ser_state_e;

endpackage

// *** dv/lvds_pixel_serializer_checker.sv ***
// Port checker for the pixel serializer, bound to its top module.
// Assumes config changes only while the lanes are idle.
`timescale 1ns/1ps
module lvds_pixel_serializer_checker
    import lvds_pixel_serializer_pkg::*;
(
    // Watched ports
    input logic        clk_sys_in,
    input logic        resetn_in,
    input logic [3:0]  address_in,
    input logic        read_in,
    input logic        write_in,
    input logic [31:0] writedata_in,
    input logic [3:0]  byteenable_in,
    input logic [31:0] readdata_out,
    input logic        waitrequest_out,
    input logic        channel_a_clock_pair_out,
    input logic        channel_a_lane0_out,
    input logic        channel_a_lane1_out,
    input logic        channel_a_lane2_out,
    input logic        channel_a_lane3_out
);
    logic [1:0] cfg_r;
    logic [1:0] cfg_nxt;
    logic [3:0] ln;
    logic       ck;
    assign ln = {channel_a_lane3_out, channel_a_lane2_out,
                 channel_a_lane1_out, channel_a_lane0_out};
    assign ck = channel_a_clock_pair_out;
    // Shadow of enable and depth, taken on the completing edge
    always_comb begin
        cfg_nxt = cfg_r;
        if (write_in && !waitrequest_out && address_in == CFG_ADDR) begin
            if (byteenable_in[0]) cfg_nxt[0] = writedata_in[DEPTH24_BIT];
            if (byteenable_in[1]) cfg_nxt[1] = writedata_in[ENABLE_BIT];
        end
    end
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) cfg_r <= 2'h0;
        else cfg_r <= cfg_nxt;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    property p_wait_one;
        (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer late");
    property p_wait_back; !waitrequest_out |=> waitrequest_out; endproperty
    a_wait_back: assert property (p_wait_back)
        else $error("wait state skipped");
    property p_unmapped;
        read_in && waitrequest_out && address_in != CFG_ADDR
            && address_in != STATUS_ADDR |=> readdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rd_hold; !read_in |=> $stable(readdata_out); endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved");
    property p_clk_pat; $fell(ck) |=> !ck[*2] ##1 ck[*2]; endproperty
    a_clk_pat: assert property (p_clk_pat)
        else $error("clock pattern wrong");
    property p_seven; $fell(ck) |-> ##5 ck && ln == 4'h0; endproperty
    a_seven: assert property (p_seven)
        else $error("more than seven slots");
    property p_lane3; !cfg_r[0] |-> !ln[3]; endproperty
    a_lane3: assert property (p_lane3)
        else $error("lane 3 active in 18-bit");
    property p_off; !cfg_r[1] |-> ln == 4'h0; endproperty
    a_off: assert property (p_off)
        else $error("lanes active while disabled");
endmodule

bind lvds_pixel_serializer lvds_pixel_serializer_checker i_chk (.*);

// *** dv/lvds_flat_panel_model.sv ***
// Panel receiver model: gathers seven slots of every lane.
// Assumes one slot per system clock, as the transmitter sends.
`timescale 1ns/1ps
module lvds_flat_panel_model
    import lvds_pixel_serializer_pkg::*;
(
    // System
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // Serial lines
    input  wire logic        clock_pair_in,
    input  wire logic        lane0_in,
    input  wire logic        lane1_in,
    input  wire logic        lane2_in,
    input  wire logic        lane3_in,
    // Decoded word, lane 3 on top
    output logic             word_valid_out,
    output logic      [27:0] word_out
);
    logic [4:0] in_w;
    logic [6:0] sh_r [5];
    assign in_w = {clock_pair_in, lane3_in, lane2_in, lane1_in, lane0_in};
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        for (int i = 0; i < 5; i++) begin
            if (!resetn_in) sh_r[i] <= 7'h00;
            else sh_r[i] <= {sh_r[i][5:0], in_w[i]};
        end
    end
    // Full pattern only after slot six, so one word per pixel
    assign word_valid_out = (sh_r[4] == CLOCK_PATTERN);
    assign word_out = {sh_r[3], sh_r[2], sh_r[1], sh_r[0]};
endmodule

// *** dv/lvds_pixel_serializer_tb_top.sv ***
// Bench: bus tasks, pixel driver and a table of depth and map modes.
// Assumes the panel model reports each decoded word.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module lvds_pixel_serializer_tb_top;
    import lvds_pixel_serializer_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [3:0]  address_in = 4'h0;
    logic        read_in = 1'b0;
    logic        write_in = 1'b0;
    logic [31:0] writedata_in = 32'h0;
    logic [3:0]  byteenable_in = 4'h0;
    logic [31:0] readdata_out;
    logic        waitrequest_out;
    logic        channel_a_clock_pair_out;
    logic        channel_a_lane0_out, channel_a_lane1_out;
    logic        channel_a_lane2_out, channel_a_lane3_out;
    logic [1:0]  pclk = 2'h0, de = 2'h0, vs = 2'h0, hs = 2'h0;
    logic [23:0] rgb [2] = '{24'h0, 24'h0};
    logic        word_valid;
    logic [27:0] word;
    logic [27:0] got [$];
    logic [4:0]  modes [6] = '{5'h00, 5'h18, 5'h0e, 5'h16, 5'h0b, 5'h1e};
    int          compares = 0, miscompares = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    lvds_pixel_serializer i_dut (.*,
        .ctrl0_pixel_clk_in(pclk[0]), .ctrl0_rgb_in(rgb[0]),
        .ctrl0_de_in(de[0]), .ctrl0_vsync_in(vs[0]), .ctrl0_hsync_in(hs[0]),
        .ctrl1_pixel_clk_in(pclk[1]), .ctrl1_rgb_in(rgb[1]),
        .ctrl1_de_in(de[1]), .ctrl1_vsync_in(vs[1]), .ctrl1_hsync_in(hs[1]));
    lvds_flat_panel_model i_panel (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .clock_pair_in(channel_a_clock_pair_out),
        .lane0_in(channel_a_lane0_out), .lane1_in(channel_a_lane1_out),
        .lane2_in(channel_a_lane2_out), .lane3_in(channel_a_lane3_out),
        .word_valid_out(word_valid), .word_out(word));
    always @(negedge clk_sys_in) begin
        if (word_valid === 1'b1) got.push_back(word);
    end
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        address_in <= a;
        writedata_in <= d;
        byteenable_in <= be;
        write_in <= wr;
        read_in <= !wr;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 20);
        q = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
        if (waitrequest_out !== 1'b0) begin
            miscompares++;
            report_and_stop();
        end
        @(posedge clk_sys_in);
    endtask
    // Pixel clock only runs for the pixel; period 800 ns
    task automatic pix(input int s, input logic [23:0] c, input logic [2:0] k);
        rgb[s] <= c;
        {de[s], vs[s], hs[s]} <= k;
        pclk[s] <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        pclk[s] <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
    endtask
    function automatic logic [27:0] exp_w(logic [23:0] c, logic [2:0] k,
                                          logic d24, logic [2:0] m);
        logic [7:0] r, g, b;
        if (d24 && m == MAP_MSB_FOURTH) begin
            r = {c[21:16], c[23:22]};
            g = {c[13:8], c[15:14]};
            b = {c[5:0], c[7:6]};
        end else begin
            {r, g, b} = c;
        end
        return {d24 ? {1'b0, b[1:0], g[1:0], r[1:0]} : 7'h00,
                k, b[7:4], b[3:2], g[7:3], g[2], r[7:2]};
    endfunction
    task automatic expect_w(input logic [27:0] e);
        logic [27:0] w;
        int n;
        n = 0;
        while (got.size() == 0 && n < 40) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (got.size() == 0) begin
            miscompares++;
            report_and_stop();
        end
        w = got.pop_front();
        `CHK(w, e)
    endtask
    initial begin
        logic [31:0] q;
        logic [23:0] c;
        logic [2:0]  k;
        logic [4:0]  m;
        repeat (12) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(posedge clk_sys_in);
        bus(1'b0, CFG_ADDR, 32'h0, 4'h0, q);
        `CHK(q, CFG_RESET)
        bus(1'b0, 4'h8, 32'h0, 4'h0, q);
        `CHK(q, 32'h0)
        bus(1'b1, CFG_ADDR, 32'h0000_0316, 4'h1, q);
        bus(1'b0, CFG_ADDR, 32'h0, 4'h0, q);
        `CHK(q, 32'h0000_0016)
        pix(0, 24'hffffff, 3'h7);
        repeat (20) @(posedge clk_sys_in);
        `CHK(got.size(), 0)
        // Back-to-back pixels in every mode, both sources
        for (int i = 0; i < 6; i++) begin
            m = modes[i];
            c = 24'hc53a96 ^ {8{3'(i)}};
            k = 3'(i + 1);
            bus(1'b1, CFG_ADDR, {22'h0, m[4], 1'b1, 3'h0, m[3], 1'b0, m[2:0]},
                4'hf, q);
            pix(int'(m[4]), c, k);
            pix(int'(m[4]), ~c, ~k);
            expect_w(exp_w(c, k, m[3], m[2:0]));
            expect_w(exp_w(~c, ~k, m[3], m[2:0]));
            bus(1'b0, STATUS_ADDR, 32'h0, 4'h0, q);
            `CHK(q[ACTIVE_BIT], 1'b1)
            `CHK(q[31:16], 16'(2 * i + 2))
        end
        repeat (110) @(posedge clk_sys_in);
        bus(1'b0, STATUS_ADDR, 32'h0, 4'h0, q);
        `CHK(q[ACTIVE_BIT], 1'b0)
        report_and_stop();
    end
endmodule
